// *** hdl/bcft_pkg.sv ***
`default_nettype none
package bcft_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] MAJ_LO_OFF   = 16'h0148;
  localparam logic [15:0] MAJ_HI_OFF   = 16'h014A;
  localparam logic [15:0] MIN_LO_OFF   = 16'h014C;
  localparam logic [15:0] MIN_HI_OFF   = 16'h014E;
  localparam logic [15:0] PERR_OFF     = 16'h0150;
  localparam logic [15:0] GAP_OFF      = 16'h0152;
  localparam logic [15:0] RT_MAP_OFF   = 16'h0154;
  localparam logic [15:0] RT_ADDR_OFF  = 16'h0156;
  localparam logic [15:0] BC_MAP_OFF   = 16'h0158;
  localparam logic [15:0] BC_ADDR_OFF  = 16'h015A;
  localparam logic [15:0] DIS_OFF      = 16'h015C;
  localparam logic [15:0] SWMASK_OFF   = 16'h015E;
  localparam logic [15:0] REV_OFF      = 16'h0180;
  localparam logic [15:0] LOST_CNT_OFF = 16'h0198;
  localparam logic [15:0] LOST_PTR_OFF = 16'h019A;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MAP_MASK     = 16'h000F;
  localparam logic [15:0] SWMASK_MASK  = 16'h07FF;
  localparam logic [15:0] GAP_RST      = 16'h0001;
  localparam logic [15:0] REG_RST      = 16'h0000;
  localparam logic [15:0] LOST_STEP    = 16'h0002;
  localparam int          DIS_BIT      = 0;
  // Cause bits of the error register
  localparam int E_MODE = 15;
  localparam int E_GAP  = 14;
  localparam int E_TMO  = 13;
  localparam int E_WC   = 12;
  localparam int E_CMD  = 11;
  localparam int E_CW   = 10;
  localparam int E_MAJ  = 7;
  localparam int E_DBA  = 6;
  localparam int E_CBA  = 5;
  localparam int E_RTC  = 4;
  localparam int E_RTCW = 2;
  localparam int E_SIMB = 1;
  // Causes reported by the sequencer as ready-made events
  localparam logic [15:0] EXT_ERR_MASK = 16'h0309;
  localparam logic [15:0] MODE_MAX     = 16'h0004;
  localparam logic [15:0] MIN_GAP_US   = 16'h001E;
  localparam logic [15:0] TMO_MIN      = 16'h0007;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam logic [3:0] PRE_LAST = 4'(CYC_PER_US - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bcft_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] rdata;
  } bcft_rsp_t;

  typedef enum logic [1:0] {MJ_IDLE, MJ_RUN, MJ_WAIT} bcft_mj_t;

endpackage
`default_nettype wire

// *** hdl/bcft_regs.sv ***
`default_nettype none
// Behaviour
// (RULE1) With major framing on, restart list when frame time since start elapses.
// (RULE2) Host writes a nonzero 32-bit major time, upper half higher offset.
// (RULE3) Major time low half is its own read/write register below the high.
// (RULE4) High register bits 15..0 are major time bits 31..16.
// (RULE5) Host marks the last block of a major-framed list.
// (RULE6) A 32-bit microsecond minor frame timer, inside or apart from major.
// (RULE7) Minor time low and high halves are read/write registers.
// (RULE8) Host marks the last block of each minor frame.
// (RULE9) Each programming error raises the flag and records its cause bit.
// (RULE10) Bit 15 invalid mode, bit 11 invalid register access command.
// (RULE11) Bit 14 when controller gap is under 30 microseconds.
// (RULE12) Bit 13 when response timeout is neither zero nor at least 7.
// (RULE13) Bit 12 word count mismatch; bit 10 both direction bits set.
// (RULE14) Bit 9 contradictory subaddress options; bit 8 zero pointer count.
// (RULE15) Bit 7 when major frame time is shorter than the list.
// (RULE16) Bits 6, 5, 4, 3: handover address, zero start, no terminals, pointers.
// (RULE17) Bit 2 neither simulate nor monitor; bit 1 both; bit 0 latency. Code raises bit 1 on control word bit 9 with broadcast enabled.
// (RULE18) Gap injection inserts the programmed extra microseconds, default 1.
// (RULE19) Controller-to-terminal handover uses 20-bit terminal header address.
// (RULE20) Terminal-to-controller handover uses 20-bit control block address.
// (RULE21) 11-bit status mask decides dynamic allocation acceptance.
// (RULE22) Microcode revision is a read-only 16-bit value.
// (RULE23) Count each new second interrupt raised while one is unserviced.
// (RULE24) Pointer to where the next lost interrupt entry is stored.
module bcft_regs #(
  parameter logic [15:0] REVISION = 16'h0100 // arbitrary value
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Register access command port
  input  wire bcft_pkg::bcft_cmd_t cmd,
  output logic                  cmd_ready,
  output bcft_pkg::bcft_rsp_t   rsp,
  // List scheduling
  input  wire logic             list_start,
  input  wire logic             list_done,
  input  wire logic             major_enable,
  input  wire logic             minor_start,
  input  wire logic             minor_done,
  input  wire logic             minor_in_major,
  output logic                  list_restart,
  output logic                  minor_next,
  // Programming checks
  input  wire logic             mode_req,
  input  wire logic [15:0]      mode_value,
  input  wire logic             bus_controller_mode,
  input  wire logic             multi_terminal_mode,
  input  wire logic             gap_check,
  input  wire logic [15:0]      gap_value,
  input  wire logic             tmo_check,
  input  wire logic [15:0]      tmo_value,
  input  wire logic             wc_check,
  input  wire logic             rt_to_rt,
  input  wire logic [4:0]       cb_word_count,
  input  wire logic [4:0]       cmd1_word_count,
  input  wire logic [4:0]       cmd2_word_count,
  input  wire logic             cw_check,
  input  wire logic [15:0]      control_word,
  input  wire logic             start_check,
  input  wire logic [15:0]      control_block_address,
  input  wire logic [5:0]       terminal_count,
  input  wire logic             rtcw_check,
  input  wire logic [15:0]      remote_terminal_cw,
  input  wire logic             broadcast_enabled,
  input  wire logic [15:0]      ext_err,
  output logic                  prog_error,
  // Gap injection
  input  wire logic             gap_inject,
  output logic                  gap_active,
  output logic                  gap_done,
  // Dynamic bus control
  input  wire logic             dba_request,
  input  wire logic [15:0]      dba_status_word,
  output logic                  dba_accept,
  output logic                  dba_reject,
  input  wire logic             handover_to_terminal,
  input  wire logic             handover_to_controller,
  output logic                  reconfig_terminal,
  output logic                  reconfig_controller,
  output logic [19:0]           reconfig_addr,
  // Second interrupt bookkeeping
  input  wire logic             irq_b_assert,
  input  wire logic             irq_b_pending
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]        maj_lo;
    logic [15:0]        maj_hi;
    logic [15:0]        min_lo;
    logic [15:0]        min_hi;
    logic [15:0]        perr;
    logic [15:0]        gap;
    logic [15:0]        rt_map;
    logic [15:0]        rt_addr;
    logic [15:0]        bc_map;
    logic [15:0]        bc_addr;
    logic [15:0]        dis;
    logic [15:0]        swmask;
    logic [15:0]        lost_cnt;
    logic [15:0]        lost_ptr;
    logic [3:0]         pre;
    bcft_pkg::bcft_mj_t mst;
    logic [31:0]        mj_el;
    logic               mn_wait;
    logic [31:0]        mn_el;
    logic               gap_act;
    logic [15:0]        gap_el;
    bcft_pkg::bcft_rsp_t rsp;
    logic               restart;
    logic               mnext;
    logic               gdone;
    logic               rc_rt;
    logic               rc_bc;
    logic [19:0]        rc_addr;
    logic               acc;
    logic               rej;
    logic               perr_evt;
  } bcft_state_t;

  bcft_state_t state_ff;
  bcft_state_t nxt_state;

  logic        us_tick;
  logic [31:0] maj_time;
  logic [31:0] min_time;

  assign us_tick  = (state_ff.pre == bcft_pkg::PRE_LAST);
  assign maj_time = {state_ff.maj_hi, state_ff.maj_lo}; // [RULE4]
  assign min_time = {state_ff.min_hi, state_ff.min_lo}; // [RULE7]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] ev;
    logic [15:0] rd;
    logic        bad;
    ev = '0;
    rd = '0;
    bad = 1'b0;
    nxt_state = state_ff;
    nxt_state.rsp = '0;
    nxt_state.restart = 1'b0;
    nxt_state.mnext = 1'b0;
    nxt_state.gdone = 1'b0;
    nxt_state.rc_rt = 1'b0;
    nxt_state.rc_bc = 1'b0;
    nxt_state.acc = 1'b0;
    nxt_state.rej = 1'b0;
    nxt_state.pre = us_tick ? 4'h0 : state_ff.pre + 4'h1;

    // Register access; writes land first so hardware updates win
    if (cmd.valid) begin
      if (cmd.addr == bcft_pkg::MAJ_LO_OFF) begin
        rd = state_ff.maj_lo;
        if (cmd.write) nxt_state.maj_lo = cmd.wdata; // [RULE3]
      end else if (cmd.addr == bcft_pkg::MAJ_HI_OFF) begin
        rd = state_ff.maj_hi;
        if (cmd.write) nxt_state.maj_hi = cmd.wdata; // [RULE4]
      end else if (cmd.addr == bcft_pkg::MIN_LO_OFF) begin
        rd = state_ff.min_lo;
        if (cmd.write) nxt_state.min_lo = cmd.wdata; // [RULE7]
      end else if (cmd.addr == bcft_pkg::MIN_HI_OFF) begin
        rd = state_ff.min_hi;
        if (cmd.write) nxt_state.min_hi = cmd.wdata; // [RULE7]
      end else if (cmd.addr == bcft_pkg::PERR_OFF) begin
        rd = state_ff.perr;
        if (cmd.write) nxt_state.perr = cmd.wdata;
      end else if (cmd.addr == bcft_pkg::GAP_OFF) begin
        rd = state_ff.gap;
        if (cmd.write) nxt_state.gap = cmd.wdata;
      end else if (cmd.addr == bcft_pkg::RT_MAP_OFF) begin
        rd = state_ff.rt_map;
        if (cmd.write) nxt_state.rt_map = cmd.wdata & bcft_pkg::MAP_MASK;
      end else if (cmd.addr == bcft_pkg::RT_ADDR_OFF) begin
        rd = state_ff.rt_addr;
        if (cmd.write) nxt_state.rt_addr = cmd.wdata;
      end else if (cmd.addr == bcft_pkg::BC_MAP_OFF) begin
        rd = state_ff.bc_map;
        if (cmd.write) nxt_state.bc_map = cmd.wdata & bcft_pkg::MAP_MASK;
      end else if (cmd.addr == bcft_pkg::BC_ADDR_OFF) begin
        rd = state_ff.bc_addr;
        if (cmd.write) nxt_state.bc_addr = cmd.wdata;
      end else if (cmd.addr == bcft_pkg::DIS_OFF) begin
        rd = state_ff.dis;
        if (cmd.write) nxt_state.dis = cmd.wdata;
      end else if (cmd.addr == bcft_pkg::SWMASK_OFF) begin
        rd = state_ff.swmask;
        if (cmd.write) begin
          nxt_state.swmask = cmd.wdata & bcft_pkg::SWMASK_MASK; // [RULE21]
        end
      end else if (cmd.addr == bcft_pkg::REV_OFF) begin
        rd = REVISION; // [RULE22]
        bad = cmd.write;
      end else if (cmd.addr == bcft_pkg::LOST_CNT_OFF) begin
        rd = state_ff.lost_cnt;
        if (cmd.write) nxt_state.lost_cnt = cmd.wdata;
      end else if (cmd.addr == bcft_pkg::LOST_PTR_OFF) begin
        rd = state_ff.lost_ptr;
        if (cmd.write) nxt_state.lost_ptr = cmd.wdata;
      end else begin
        bad = 1'b1;
      end
      nxt_state.rsp.valid = 1'b1;
      nxt_state.rsp.err = bad;
      nxt_state.rsp.rdata = bad ? 16'h0000 : rd;
      ev[bcft_pkg::E_CMD] = bad; // [RULE10]
    end

    // ----------------------------------------------------------------
    // Major frame
    // ----------------------------------------------------------------
    if (us_tick && state_ff.mst != bcft_pkg::MJ_IDLE) begin
      nxt_state.mj_el = state_ff.mj_el + 32'h1;
    end
    case (state_ff.mst)
      bcft_pkg::MJ_IDLE: begin
        if (list_start) begin
          nxt_state.mst = bcft_pkg::MJ_RUN;
          nxt_state.mj_el = '0;
        end
      end
      bcft_pkg::MJ_RUN: begin
        if (list_done && major_enable) begin
          // Overrun: report and restart at once
          if (state_ff.mj_el > maj_time) begin
            ev[bcft_pkg::E_MAJ] = 1'b1; // [RULE15]
            nxt_state.restart = 1'b1;
            nxt_state.mj_el = '0;
          end else begin
            nxt_state.mst = bcft_pkg::MJ_WAIT;
          end
        end else if (list_done) begin
          nxt_state.mst = bcft_pkg::MJ_IDLE;
        end
      end
      bcft_pkg::MJ_WAIT: begin
        if (state_ff.mj_el >= maj_time) begin
          nxt_state.restart = 1'b1; // [RULE1]
          nxt_state.mj_el = '0;
          nxt_state.mst = bcft_pkg::MJ_RUN;
        end
      end
      default: nxt_state.mst = bcft_pkg::MJ_IDLE;
    endcase

    // ----------------------------------------------------------------
    // Minor frame
    // ----------------------------------------------------------------
    if (us_tick) nxt_state.mn_el = state_ff.mn_el + 32'h1; // [RULE6]
    if (minor_done) nxt_state.mn_wait = 1'b1;
    if (state_ff.mn_wait && state_ff.mn_el >= min_time) begin
      nxt_state.mnext = 1'b1;
      nxt_state.mn_wait = 1'b0;
      nxt_state.mn_el = '0;
    end
    // Locked to the major frame when asked to
    if (minor_start ||
        (minor_in_major && (list_start || nxt_state.restart))) begin
      nxt_state.mn_el = '0; // [RULE6]
      nxt_state.mn_wait = 1'b0;
    end

    // ----------------------------------------------------------------
    // Gap injection
    // ----------------------------------------------------------------
    if (gap_inject && !state_ff.gap_act) begin
      nxt_state.gap_act = 1'b1;
      nxt_state.gap_el = '0;
    end else if (state_ff.gap_act) begin
      if (state_ff.gap_el >= state_ff.gap) begin
        nxt_state.gap_act = 1'b0; // [RULE18]
        nxt_state.gdone = 1'b1;
      end else if (us_tick) begin
        nxt_state.gap_el = state_ff.gap_el + 16'h1;
      end
    end

    // ----------------------------------------------------------------
    // Dynamic bus control
    // ----------------------------------------------------------------
    if (dba_request && multi_terminal_mode) begin
      if (((dba_status_word & state_ff.swmask) == 16'h0000) &&
          !state_ff.dis[bcft_pkg::DIS_BIT]) begin
        nxt_state.acc = 1'b1; // [RULE21]
      end else begin
        nxt_state.rej = 1'b1;
      end
    end
    if (handover_to_terminal) begin
      nxt_state.rc_rt = 1'b1;
      nxt_state.rc_addr = {state_ff.rt_map[3:0], state_ff.rt_addr}; // [RULE19]
      ev[bcft_pkg::E_DBA] = ({state_ff.rt_map, state_ff.rt_addr} == '0);
    end else if (handover_to_controller) begin
      nxt_state.rc_bc = 1'b1;
      nxt_state.rc_addr = {state_ff.bc_map[3:0], state_ff.bc_addr}; // [RULE20]
      ev[bcft_pkg::E_DBA] = ({state_ff.bc_map, state_ff.bc_addr} == '0);
    end

    // ----------------------------------------------------------------
    // Lost second interrupts
    // ----------------------------------------------------------------
    if (irq_b_assert && irq_b_pending) begin
      nxt_state.lost_cnt = nxt_state.lost_cnt + 16'h1; // [RULE23]
      nxt_state.lost_ptr = nxt_state.lost_ptr + bcft_pkg::LOST_STEP; // [RULE24]
    end

    // ----------------------------------------------------------------
    // Programming error causes
    // ----------------------------------------------------------------
    if (mode_req && mode_value > bcft_pkg::MODE_MAX) begin
      ev[bcft_pkg::E_MODE] = 1'b1; // [RULE10]
    end
    if (gap_check && bus_controller_mode &&
        gap_value < bcft_pkg::MIN_GAP_US) begin
      ev[bcft_pkg::E_GAP] = 1'b1; // [RULE11]
    end
    if (tmo_check && tmo_value != 16'h0000 &&
        tmo_value < bcft_pkg::TMO_MIN) begin
      ev[bcft_pkg::E_TMO] = 1'b1; // [RULE12]
    end
    if (wc_check && (cb_word_count != cmd1_word_count ||
        (rt_to_rt && cmd1_word_count != cmd2_word_count))) begin
      ev[bcft_pkg::E_WC] = 1'b1; // [RULE13]
    end
    if (cw_check && control_word[15] && control_word[14]) begin
      ev[bcft_pkg::E_CW] = 1'b1; // [RULE13]
    end
    // Zero start address is only reported; start still proceeds
    if (start_check && control_block_address == 16'h0000) begin
      ev[bcft_pkg::E_CBA] = 1'b1; // [RULE16]
    end
    if (start_check && multi_terminal_mode && terminal_count == '0) begin
      ev[bcft_pkg::E_RTC] = 1'b1; // [RULE16]
    end
    if (rtcw_check && !remote_terminal_cw[9] && !remote_terminal_cw[8]) begin
      ev[bcft_pkg::E_RTCW] = 1'b1; // [RULE17]
    end
    if (rtcw_check && remote_terminal_cw[9] && broadcast_enabled) begin
      ev[bcft_pkg::E_SIMB] = 1'b1; // [RULE17]
    end
    // Pointer, subaddress option, ring pointer and latency causes
    ev = ev | (ext_err & bcft_pkg::EXT_ERR_MASK); // [RULE14] [RULE16] [RULE17]
    // A cause landing with a host write survives it
    nxt_state.perr = nxt_state.perr | ev; // [RULE9]
    nxt_state.perr_evt = |ev; // [RULE9]
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '0;
      state_ff.gap <= bcft_pkg::GAP_RST; // [RULE18]
      state_ff.mst <= bcft_pkg::MJ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready           = 1'b1;
  assign rsp                 = state_ff.rsp;
  assign list_restart        = state_ff.restart;
  assign minor_next          = state_ff.mnext;
  assign prog_error          = state_ff.perr_evt;
  assign gap_active          = state_ff.gap_act;
  assign gap_done            = state_ff.gdone;
  assign dba_accept          = state_ff.acc;
  assign dba_reject          = state_ff.rej;
  assign reconfig_terminal   = state_ff.rc_rt;
  assign reconfig_controller = state_ff.rc_bc;
  assign reconfig_addr       = state_ff.rc_addr;

endmodule
`default_nettype wire

// *** verification/bcft_regs_checker.sv ***
`default_nettype none
module bcft_regs_checker #(
  parameter logic [15:0] REVISION = 16'h0100
) (
  // Clock, reset and register port
  input wire logic                clk,
  input wire logic                nrst,
  input wire bcft_pkg::bcft_cmd_t cmd,
  input wire bcft_pkg::bcft_rsp_t rsp,
  // Events and answers
  input wire logic                list_restart,
  input wire logic                mode_req,
  input wire logic [15:0]         mode_value,
  input wire logic                tmo_check,
  input wire logic [15:0]         tmo_value,
  input wire logic [15:0]         ext_err,
  input wire logic                prog_error,
  input wire logic                gap_inject,
  input wire logic                gap_active,
  input wire logic                dba_request,
  input wire logic                multi_terminal_mode,
  input wire logic                dba_accept,
  input wire logic                dba_reject,
  input wire logic                handover_to_terminal,
  input wire logic                reconfig_terminal
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  rev_read_a:
    assert property (cmd.valid && !cmd.write && cmd.addr == 16'h0180
      |=> rsp.valid && !rsp.err && rsp.rdata == REVISION)
    else $error("revision read wrong");
  rev_write_a:
    assert property (cmd.valid && cmd.write && cmd.addr == 16'h0180
      |=> rsp.err && rsp.rdata == 16'h0000 && prog_error)
    else $error("revision write not refused");
  restart_pulse_a:
    assert property (list_restart |=> !list_restart)
    else $error("restart longer than one cycle");
  bad_mode_a:
    assert property (mode_req && mode_value > 16'h0004 |=> prog_error)
    else $error("invalid mode not flagged");
  bad_timeout_a:
    assert property (tmo_check && tmo_value != 16'h0000
      && tmo_value < 16'h0007 |=> prog_error)
    else $error("bad timeout not flagged");
  ext_cause_a:
    assert property ((ext_err & 16'h0309) != 16'h0000 |=> prog_error)
    else $error("sequencer cause not flagged");
  gap_start_a:
    assert property (gap_inject && !gap_active |=> gap_active)
    else $error("gap did not start");
  dba_answer_a:
    assert property (dba_request && multi_terminal_mode
      |=> dba_accept != dba_reject)
    else $error("allocation answer missing");
  handover_pulse_a:
    assert property (handover_to_terminal
      |=> reconfig_terminal ##1 !reconfig_terminal)
    else $error("terminal reconfig pulse wrong");
endmodule

bind bcft_regs bcft_regs_checker #(.REVISION(REVISION)) i_chk (
  .clk, .nrst, .cmd, .rsp, .list_restart, .mode_req, .mode_value,
  .tmo_check, .tmo_value, .ext_err, .prog_error, .gap_inject, .gap_active,
  .dba_request, .multi_terminal_mode, .dba_accept, .dba_reject,
  .handover_to_terminal, .reconfig_terminal
);
`default_nettype wire

// *** verification/bcft_host.sv ***
`default_nettype none
module bcft_host (
  // Clock
  input  wire logic           clk,
  // Register access command
  output var bcft_pkg::bcft_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd = '0;
  // Released lines carry inverted garbage, not the old value
  task automatic acc(input logic w, input logic [15:0] a, d);
    @(negedge clk);
    cmd <= {1'b1, w, a, d};
    @(negedge clk);
    cmd <= {1'b0, ~w, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// *** verification/bcft_regs_tb.sv ***
`default_nettype none
module bcft_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  bcft_pkg::bcft_cmd_t cmd;
  bcft_pkg::bcft_rsp_t rsp;
  logic list_start, list_done, major_enable, minor_start, minor_done;
  logic mode_req, bus_controller_mode, multi_terminal_mode, gap_check;
  logic tmo_check, wc_check, rt_to_rt, cw_check, start_check, gap_inject;
  logic rtcw_check, broadcast_enabled;
  logic dba_request, handover_to_terminal, handover_to_controller;
  logic irq_b_assert, irq_b_pending, cmd_ready, list_restart, minor_next;
  logic prog_error, gap_active, gap_done, dba_accept, dba_reject;
  logic reconfig_terminal, reconfig_controller;
  logic [15:0] mode_value, gap_value, tmo_value, control_word, ext_err;
  logic [15:0] control_block_address, dba_status_word, off, msk, v;
  logic [15:0] remote_terminal_cw;
  logic [4:0]  cb_word_count, cmd1_word_count, cmd2_word_count;
  logic [19:0] reconfig_addr;
  logic [17:0] notes[$];
  logic [17:0] nt;
  logic [15:0] lf = 16'h58FB;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n;

  always #50 clk = ~clk;
  bcft_host i_host (.clk, .cmd);
  bcft_regs i_dut (
    .*, .minor_in_major(1'b0), .terminal_count(6'h01)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(input logic [19:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, d,
                     input logic [17:0] note);
    notes.push_back(note);
    i_host.acc(w, a, d);
  endtask
  task automatic rd(input logic [15:0] a, e);
    acc(1'b0, a, 16'h0000, {2'b10, e});
  endtask
  task automatic wr(input logic [15:0] a, d);
    acc(1'b1, a, d, 18'h00000);
  endtask
  task automatic w32(input logic [15:0] a, input logic [31:0] d);
    wr(a, d[15:0]);
    wr(a + 16'h0002, d[31:16]);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic waitp(input int sel, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (!(sel == 0 ? list_restart : sel == 1 ? minor_next : gap_done)
               && cnt < 200);
  endtask
  task automatic tally_and_finish();
    if (notes.size() != 0) n_fail++;
    $display("compares=%0d errors=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Answer watcher: every response is matched against the oldest note
  always @(negedge clk) begin
    if (rsp.valid === 1'b1) begin
      nt = notes.pop_front();
      chk({2'b0, cmd_ready, rsp.err, nt[17] ? rsp.rdata : 16'h0000},
          {2'b0, 1'b1, nt[16], nt[17] ? nt[15:0] : 16'h0000});
    end
  end

  // Whole run needs about 220 cycles; 20000 means a hang
  initial begin
    #2_000_000;
    n_fail++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {list_start, list_done, major_enable, minor_start, minor_done, mode_req,
     bus_controller_mode, multi_terminal_mode, gap_check, tmo_check, wc_check,
     rt_to_rt, cw_check, start_check, gap_inject, dba_request,
     handover_to_terminal, handover_to_controller, irq_b_assert,
     irq_b_pending} = '0;
    {mode_value, gap_value, tmo_value, control_word, ext_err} = '0;
    {control_block_address, dba_status_word} = '0;
    {remote_terminal_cw, rtcw_check, broadcast_enabled} = '0;
    {cb_word_count, cmd1_word_count, cmd2_word_count} = '0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 14; i++) begin
      off = i < 12 ? 16'h0148 + 16'(2 * i) : 16'h0198 + 16'(2 * (i - 12));
      msk = (off == 16'h0154 || off == 16'h0158) ? 16'h000F
          : off == 16'h015E ? 16'h07FF : 16'hFFFF;
      v = rnd();
      rd(off, off == 16'h0152 ? 16'h0001 : 16'h0000);
      wr(off, v);
      rd(off, v & msk);
    end
    wr(16'h0150, 16'h0000);
    rd(16'h0180, 16'h0100);
    acc(1'b1, 16'h0180, 16'h1234, 18'h10000);
    acc(1'b0, 16'h0160, 16'h0000, 18'h10000);
    rd(16'h0150, 16'h0800);
    wr(16'h0150, 16'h0000);
    // Legal mode and timeout edge values first, then eleven causes (0xF72D) in one cycle
    @(negedge clk);
    {mode_req, gap_check, tmo_check} = 3'b111;
    {mode_value, gap_value, tmo_value} = {16'h0004, 16'h001D, 16'h0007};
    @(negedge clk);
    {bus_controller_mode, wc_check, cw_check, start_check, rt_to_rt} = '1;
    {mode_value, tmo_value, control_word} = {16'h0005, 16'h0003, 16'hC000};
    {cb_word_count, cmd1_word_count, cmd2_word_count} = {5'h2, 5'h2, 5'h3};
    ext_err = 16'h0309;
    {rtcw_check, broadcast_enabled} = 2'b11;
    @(negedge clk);
    {mode_req, gap_check, tmo_check, wc_check, cw_check, start_check} = '0;
    {ext_err, rtcw_check} = 17'h00000;
    rd(16'h0150, 16'hF72D);
    v = rnd();
    wr(16'h0154, 16'h000A);
    wr(16'h0156, v);
    pulse(handover_to_terminal);
    chk(reconfig_addr, {4'hA, v});
    v = rnd();
    wr(16'h0158, 16'h0003);
    wr(16'h015A, v);
    pulse(handover_to_controller);
    chk({reconfig_controller, reconfig_addr[18:0]}, {1'b1, 3'h3, v});
    multi_terminal_mode = 1'b1;
    wr(16'h015E, 16'h0004);
    wr(16'h015C, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) wr(16'h015C, 16'h0001);
      dba_status_word = k == 0 ? 16'h0004 : 16'h0008;
      pulse(dba_request);
      chk({18'h0, dba_accept, dba_reject}, k == 1 ? 20'h2 : 20'h1);
    end
    wr(16'h0198, 16'hFFFF);
    v = rnd();
    wr(16'h019A, v);
    pulse(irq_b_assert);
    irq_b_pending = 1'b1;
    pulse(irq_b_assert);
    rd(16'h0198, 16'h0000);
    rd(16'h019A, v + 16'h0002);
    w32(16'h0148, 32'h0000_0003);
    w32(16'h014C, 32'h0000_0002);
    wr(16'h0152, 16'h0001);
    major_enable = 1'b1;
    pulse(list_start);
    // This pulse stands for the marked last block of the list
    pulse(list_done);
    waitp(0, n);
    chk(20'(n >= 15 && n <= 42), 20'h1);
    // Minor frame closed by its marked last block
    pulse(minor_start);
    pulse(minor_done);
    waitp(1, n);
    chk(20'(n >= 8 && n <= 32), 20'h1);
    pulse(gap_inject);
    waitp(2, n);
    chk(20'(n >= 1 && n <= 22), 20'h1);
    repeat (3) @(negedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
